//--- efm_regs.svh
// register offsets, field positions, reset values and constants of the flow matcher
`ifndef EFM_REGS_SVH
`define EFM_REGS_SVH

// ****************************************
// frame constants
// ****************************************
`define EFM_TPID_CTAG 16'h8100
`define EFM_TPID_ITAG 16'h88E7
`define EFM_LEN_LIMIT 16'h0600
`define EFM_IG_BIT 40

// ****************************************
// register map
// ****************************************
`define EFM_ADDR_W 12
`define EFM_OFS_GLOBAL 12'h000
`define EFM_OFS_STATUS 12'h004
`define EFM_FLOW_PAGE 4'h1
`define EFM_FW_CTRL 3'h0
`define EFM_FW_ADDR_LO 3'h1
`define EFM_FW_ADDR_HI 3'h2
`define EFM_FW_TAG1 3'h3
`define EFM_FW_TAG2 3'h4
`define EFM_FW_RANGE 3'h5

// ****************************************
// field positions
// ****************************************
`define EFM_G_BB 16
`define EFM_HI_LSB 16
`define EFM_C_EN 0
`define EFM_C_T1 1
`define EFM_C_T2 2
`define EFM_C_FTM 3
`define EFM_C_VER 4
`define EFM_C_RM 5
`define EFM_C_ASEL 7
`define EFM_C_AMODE 9
`define EFM_C_TCNT 12
`define EFM_C_GRP 14
`define EFM_C_CHM 16

// ****************************************
// reset values and responses
// ****************************************
`define EFM_TPID_RESET 16'h88A8
`define EFM_RESP_OKAY 2'h0
`define EFM_RESP_SLVERR 2'h2

`endif

//--- efm_pkg.sv
// types shared by the flow matcher
package efm_pkg;
   typedef enum logic [1:0] {
      EFM_RM_NONE = 2'b00,
      EFM_RM_TAG1 = 2'b01,
      EFM_RM_TAG2 = 2'b10
   } efm_rmode_t;

   typedef enum logic [1:0] {
      EFM_AS_DA = 2'b00,
      EFM_AS_SA = 2'b01,
      EFM_AS_EITHER = 2'b10
   } efm_asel_t;

   typedef struct packed {
      logic en;
      logic [7:0] chmask;
      logic t1type;
      logic t2type;
      logic ftm;
      logic ver;
      logic [1:0] rmode;
      logic [1:0] asel;
      logic [2:0] amode;
      logic [1:0] tcnt;
      logic grp;
      logic [47:0] addr;
      logic [11:0] m1;
      logic [11:0] k1;
      logic [11:0] m2;
      logic [11:0] k2;
      logic [11:0] lo;
      logic [11:0] hi;
   } efm_flow_t;
endpackage

//--- efm_matcher.sv
// per-flow ethernet header matcher with an axi4-lite register slave
// Notes on behaviour
// - no backbone mode: tag type 0 is tpid 8100, 1 the global tpid
// - backbone mode: tag 1 type 0 means service tag plus I-tag, 1 means I-tag
// - backbone mode: second tag is always an I-tag, its type bit ignored
// - frame type mode 0 accepts only type 2 frames without llc/snap
// - mode 1: length below 0600 needs llc/snap, ethertype forbids it
// - verify off: tags parsed, values unchecked; I-tag still checked in backbone
// - verify on: tag count and tag values are checked
// - range mode 0 none, 1 tag 1, 2 tag 2
// - each flow holds a 48-bit address compared with the selected field
// - address select: 0 destination, 1 source, 2 either, 3 reserved
// - unicast/multicast modes look only at the group bit
// - tag 1 id compared with its match value under its mask
// - tag 2 id compared with its match value under its mask
// - no backbone mode: selected tag id must lie within the limits
// - backbone mode: limits form the expected I-tag service id
// - two next-protocol groups; a per-flow bit selects one
// - flows split freely between groups, at most eight flows
// - per-flow enable bit and per-channel use bits
// - per-flow expected tag count 0, 1 or 2
// - backbone enable exists only in the first comparator
`include "efm_regs.svh"

module efm_matcher #(
   parameter int NUM_FLOWS = 8,
   parameter int NUM_CH = 4,
   parameter bit IS_FIRST = 1'b1
) (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic [`EFM_ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [`EFM_ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic hdr_valid,
   input wire logic [2:0] hdr_channel,
   input wire logic [47:0] hdr_da,
   input wire logic [47:0] hdr_sa,
   input wire logic [15:0] hdr_type_len,
   input wire logic hdr_llc_snap,
   input wire logic [1:0] hdr_tag_count,
   input wire logic [15:0] hdr_tag1_tpid,
   input wire logic [11:0] hdr_tag1_vid,
   input wire logic [15:0] hdr_tag2_tpid,
   input wire logic [11:0] hdr_tag2_vid,
   input wire logic [23:0] hdr_itag_sid,
   output logic match_valid,
   output logic [NUM_FLOWS-1:0] match_flows,
   output logic [NUM_FLOWS-1:0] match_group
);
   import efm_pkg::*;

   // ****************************************
   // state
   // ****************************************
   typedef struct packed {
      efm_flow_t [NUM_FLOWS-1:0] flow;
      logic [15:0] tpid;
      logic bb_en;
      logic aw_h;
      logic [`EFM_ADDR_W-1:0] awaddr;
      logic w_h;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic mvalid;
      logic [NUM_FLOWS-1:0] mflows;
      logic [NUM_FLOWS-1:0] mgroup;
   } efm_state_t;

   efm_state_t st;
   efm_state_t next_st;
   logic bb_mode;
   logic [NUM_FLOWS-1:0] en_v;
   logic [NUM_FLOWS-1:0] ch_v;
   logic [NUM_FLOWS-1:0] ftm_v;
   logic [NUM_FLOWS-1:0] cnt_bad_v;
   logic [NUM_FLOWS-1:0] grp_v;
   logic [NUM_FLOWS-1:0] hit_v;
   logic [NUM_FLOWS-1:0] ver_v;

   // ****************************************
   // register access helpers
   // ****************************************
   // returns {ok, data}; unmapped or out-of-range flow reads give not ok
   function automatic logic [32:0] rd_word(efm_state_t s, logic [`EFM_ADDR_W-1:0] a);
      logic [31:0] d;
      logic ok;
      efm_flow_t f;
      d = 32'h0000_0000;
      ok = 1'b1;
      f = s.flow[a[7:5] % NUM_FLOWS];
      if (a[1:0] != 2'h0) begin
         ok = 1'b0;
      end else if (a == `EFM_OFS_GLOBAL) begin
         d[15:0] = s.tpid;
         d[`EFM_G_BB] = s.bb_en;
      end else if (a == `EFM_OFS_STATUS) begin
         d[NUM_FLOWS-1:0] = s.mflows;
      end else if (a[11:8] == `EFM_FLOW_PAGE && int'(a[7:5]) < NUM_FLOWS) begin
         unique case (a[4:2])
            `EFM_FW_CTRL: begin
               d[`EFM_C_EN] = f.en;
               d[`EFM_C_T1] = f.t1type;
               d[`EFM_C_T2] = f.t2type;
               d[`EFM_C_FTM] = f.ftm;
               d[`EFM_C_VER] = f.ver;
               d[`EFM_C_RM +: 2] = f.rmode;
               d[`EFM_C_ASEL +: 2] = f.asel;
               d[`EFM_C_AMODE +: 3] = f.amode;
               d[`EFM_C_TCNT +: 2] = f.tcnt;
               d[`EFM_C_GRP] = f.grp;
               d[`EFM_C_CHM +: NUM_CH] = f.chmask[NUM_CH-1:0];
            end
            `EFM_FW_ADDR_LO: d = f.addr[31:0];
            `EFM_FW_ADDR_HI: d[15:0] = f.addr[47:32];
            `EFM_FW_TAG1: d = {4'h0, f.k1, 4'h0, f.m1};
            `EFM_FW_TAG2: d = {4'h0, f.k2, 4'h0, f.m2};
            `EFM_FW_RANGE: d = {4'h0, f.hi, 4'h0, f.lo};
            default: ok = 1'b0;
         endcase
      end else begin
         ok = 1'b0;
      end
      return {ok, d};
   endfunction

   // read-modify-write with byte strobes; returns the updated state
   function automatic efm_state_t wr_word(efm_state_t s, logic [`EFM_ADDR_W-1:0] a,
                                          logic [31:0] wd, logic [3:0] be);
      logic [32:0] old;
      logic [31:0] d;
      efm_flow_t f;
      logic [2:0] idx;
      old = rd_word(s, a);
      idx = a[7:5];
      for (int b = 0; b < 4; b++) begin
         d[b*8 +: 8] = be[b] ? wd[b*8 +: 8] : old[b*8 +: 8];
      end
      f = s.flow[idx % NUM_FLOWS];
      if (a == `EFM_OFS_GLOBAL) begin
         s.tpid = d[15:0];
         // the second comparator never holds a backbone enable
         s.bb_en = IS_FIRST & d[`EFM_G_BB];
      end else if (old[32] && a[11:8] == `EFM_FLOW_PAGE) begin
         unique case (a[4:2])
            `EFM_FW_CTRL: begin
               f.en = d[`EFM_C_EN];
               f.t1type = d[`EFM_C_T1];
               f.t2type = d[`EFM_C_T2];
               f.ftm = d[`EFM_C_FTM];
               f.ver = d[`EFM_C_VER];
               f.rmode = d[`EFM_C_RM +: 2];
               f.asel = d[`EFM_C_ASEL +: 2];
               f.amode = d[`EFM_C_AMODE +: 3];
               f.tcnt = d[`EFM_C_TCNT +: 2];
               f.grp = d[`EFM_C_GRP];
               f.chmask = 8'h00;
               f.chmask[NUM_CH-1:0] = d[`EFM_C_CHM +: NUM_CH];
            end
            `EFM_FW_ADDR_LO: f.addr[31:0] = d;
            `EFM_FW_ADDR_HI: f.addr[47:32] = d[15:0];
            `EFM_FW_TAG1: begin
               f.m1 = d[11:0];
               f.k1 = d[`EFM_HI_LSB +: 12];
            end
            `EFM_FW_TAG2: begin
               f.m2 = d[11:0];
               f.k2 = d[`EFM_HI_LSB +: 12];
            end
            `EFM_FW_RANGE: begin
               f.lo = d[11:0];
               f.hi = d[`EFM_HI_LSB +: 12];
            end
            default: f = f;
         endcase
         s.flow[idx % NUM_FLOWS] = f;
      end
      return s;
   endfunction

   // ****************************************
   // flow comparison
   // ****************************************
   function automatic logic addr_hit(logic [47:0] a, efm_flow_t f);
      logic ig;
      ig = a[`EFM_IG_BIT];
      return (f.amode[0] & (a == f.addr))
           | (f.amode[1] & ~ig)
           | (f.amode[2] & ig);
   endfunction

   function automatic logic flow_hit(efm_flow_t f, logic bb, logic [15:0] tpid,
                                     logic [2:0] ch);
      logic [15:0] exp1;
      logic [15:0] exp2;
      logic ft_ok;
      logic tag_ok;
      logic rng_ok;
      logic adr_ok;
      logic t1_m;
      logic t2_m;
      logic itag_ok;
      exp1 = f.t1type ? tpid : `EFM_TPID_CTAG;
      exp2 = f.t2type ? tpid : `EFM_TPID_CTAG;
      t1_m = ((hdr_tag1_vid ^ f.m1) & f.k1) == 12'h000;
      t2_m = ((hdr_tag2_vid ^ f.m2) & f.k2) == 12'h000;
      if (f.ftm) begin
         if (hdr_type_len < `EFM_LEN_LIMIT) begin
            ft_ok = hdr_llc_snap;
         end else begin
            ft_ok = ~hdr_llc_snap;
         end
      end else begin
         ft_ok = (hdr_type_len >= `EFM_LEN_LIMIT) & ~hdr_llc_snap;
      end
      if (bb) begin
         // limits carry the service id; no range check here
         if (f.t1type) begin
            itag_ok = hdr_tag1_tpid == `EFM_TPID_ITAG;
         end else begin
            itag_ok = hdr_tag2_tpid == `EFM_TPID_ITAG;
         end
         itag_ok = itag_ok & (hdr_itag_sid == {f.hi, f.lo});
         if (!f.ver) begin
            tag_ok = itag_ok;
         end else if (f.t1type) begin
            tag_ok = itag_ok & (hdr_tag_count == 2'd1);
         end else begin
            tag_ok = itag_ok & (hdr_tag_count == 2'd2) & (hdr_tag1_tpid == tpid) & t1_m;
         end
      end else begin
         unique case (f.rmode)
            EFM_RM_TAG1: rng_ok = hdr_tag1_vid >= f.lo && hdr_tag1_vid <= f.hi;
            EFM_RM_TAG2: rng_ok = hdr_tag2_vid >= f.lo && hdr_tag2_vid <= f.hi;
            default: rng_ok = 1'b1;
         endcase
         if (!f.ver) begin
            tag_ok = 1'b1;
         end else begin
            tag_ok = (hdr_tag_count == f.tcnt) & rng_ok
                   & ((f.tcnt < 2'd1) | ((hdr_tag1_tpid == exp1) & t1_m))
                   & ((f.tcnt < 2'd2) | ((hdr_tag2_tpid == exp2) & t2_m));
         end
      end
      unique case (f.asel)
         EFM_AS_DA: adr_ok = addr_hit(hdr_da, f);
         EFM_AS_SA: adr_ok = addr_hit(hdr_sa, f);
         EFM_AS_EITHER: adr_ok = addr_hit(hdr_da, f) | addr_hit(hdr_sa, f);
         default: adr_ok = 1'b0;
      endcase
      // no mode bit set leaves the address unchecked
      if (f.amode == 3'h0) begin
         adr_ok = 1'b1;
      end
      return f.en & f.chmask[ch] & ft_ok & tag_ok & adr_ok;
   endfunction

   // ****************************************
   // next state
   // ****************************************
   always_comb begin
      logic [32:0] rd;
      rd = rd_word(st, s_axi_araddr);
      next_st = st;
      bb_mode = st.bb_en & IS_FIRST;
      for (int i = 0; i < NUM_FLOWS; i++) begin
         en_v[i] = st.flow[i].en;
         ch_v[i] = st.flow[i].chmask[hdr_channel];
         ftm_v[i] = st.flow[i].ftm;
         cnt_bad_v[i] = ~bb_mode & (hdr_tag_count != st.flow[i].tcnt);
         ver_v[i] = st.flow[i].ver;
         grp_v[i] = st.flow[i].grp;
         hit_v[i] = flow_hit(st.flow[i], bb_mode, st.tpid, hdr_channel);
      end
      // write channel: address and data taken in either order
      if (s_axi_awvalid && s_axi_awready) begin
         next_st.aw_h = 1'b1;
         next_st.awaddr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         next_st.w_h = 1'b1;
         next_st.wdata = s_axi_wdata;
         next_st.wstrb = s_axi_wstrb;
      end
      if (st.aw_h && st.w_h) begin
         next_st = wr_word(next_st, st.awaddr, st.wdata, st.wstrb);
         next_st.aw_h = 1'b0;
         next_st.w_h = 1'b0;
         next_st.bvalid = 1'b1;
         next_st.bresp = rd_word(st, st.awaddr) >> 32 != 33'h0 ? `EFM_RESP_OKAY
                       : `EFM_RESP_SLVERR;
      end else if (st.bvalid && s_axi_bready) begin
         next_st.bvalid = 1'b0;
      end
      // read channel: one cycle from address to data
      if (s_axi_arvalid && s_axi_arready) begin
         next_st.rvalid = 1'b1;
         next_st.rdata = rd[31:0];
         next_st.rresp = rd[32] ? `EFM_RESP_OKAY : `EFM_RESP_SLVERR;
      end else if (st.rvalid && s_axi_rready) begin
         next_st.rvalid = 1'b0;
      end
      // matcher result lags the header by one cycle
      next_st.mvalid = hdr_valid;
      if (hdr_valid) begin
         next_st.mflows = hit_v;
         next_st.mgroup = grp_v;
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         st <= '0;
         st.tpid <= `EFM_TPID_RESET;
      end else begin
         st <= next_st;
      end
   end

   // ****************************************
   // outputs
   // ****************************************
   // a held address or data blocks a second one until the response leaves
   assign s_axi_awready = ~st.aw_h & ~st.bvalid;
   assign s_axi_wready = ~st.w_h & ~st.bvalid;
   assign s_axi_bvalid = st.bvalid;
   assign s_axi_bresp = st.bresp;
   assign s_axi_arready = ~st.rvalid;
   assign s_axi_rvalid = st.rvalid;
   assign s_axi_rdata = st.rdata;
   assign s_axi_rresp = st.rresp;
   assign match_valid = st.mvalid;
   assign match_flows = st.mflows;
   assign match_group = st.mgroup;

   // ****************************************
   // assertions
   // ****************************************
   sequence s_hdr_in;
      hdr_valid;
   endsequence

   sequence s_result;
      match_valid;
   endsequence

   property p_latency;
      @(posedge clk_sys) disable iff (rst)
      s_hdr_in |=> s_result;
   endproperty
   a_latency: assert property (p_latency) else $error("no result after header");

   property p_quiet;
      @(posedge clk_sys) disable iff (rst)
      !hdr_valid |=> !match_valid;
   endproperty
   a_quiet: assert property (p_quiet) else $error("result without header");

   property p_enable;
      @(posedge clk_sys) disable iff (rst)
      s_hdr_in ##1 s_result |-> (match_flows & ~$past(en_v)) == '0;
   endproperty
   a_enable: assert property (p_enable) else $error("disabled flow matched");

   property p_channel;
      @(posedge clk_sys) disable iff (rst)
      s_hdr_in ##1 s_result |-> (match_flows & ~$past(ch_v)) == '0;
   endproperty
   a_channel: assert property (p_channel) else $error("flow matched on masked channel");

   property p_type2_only;
      @(posedge clk_sys) disable iff (rst)
      hdr_valid && hdr_type_len < `EFM_LEN_LIMIT |=> (match_flows & ~$past(ftm_v)) == '0;
   endproperty
   a_type2_only: assert property (p_type2_only) else $error("length frame in type 2 mode");

   property p_snap_needed;
      @(posedge clk_sys) disable iff (rst)
      hdr_valid && hdr_type_len < `EFM_LEN_LIMIT && !hdr_llc_snap |=> match_flows == '0;
   endproperty
   a_snap_needed: assert property (p_snap_needed) else $error("type 1 without llc/snap");

   property p_group;
      @(posedge clk_sys) disable iff (rst)
      s_hdr_in ##1 s_result |-> match_group == $past(grp_v);
   endproperty
   a_group: assert property (p_group) else $error("group select not reported");

   // outside backbone mode, a verified flow whose tag count differs from the header must stay silent
   property p_count;
      @(posedge clk_sys) disable iff (rst)
      hdr_valid |=> (match_flows & $past(cnt_bad_v & ver_v)) == '0;
   endproperty
   a_count: assert property (p_count) else $error("tag count mismatch matched");

   property p_second_cmp;
      @(posedge clk_sys) disable iff (rst)
      !IS_FIRST |-> !bb_mode;
   endproperty
   a_second_cmp: assert property (p_second_cmp) else $error("backbone in second comparator");
endmodule // efm_matcher

//--- efm_hdr_src.sv
// header source model standing in for the frame-header parsing pipeline
module efm_hdr_src (
   input wire logic clk_sys,
   output logic hdr_valid,
   output logic [2:0] hdr_channel,
   output logic [47:0] hdr_da,
   output logic [47:0] hdr_sa,
   output logic [15:0] hdr_type_len,
   output logic hdr_llc_snap,
   output logic [1:0] hdr_tag_count,
   output logic [15:0] hdr_tag1_tpid,
   output logic [11:0] hdr_tag1_vid,
   output logic [15:0] hdr_tag2_tpid,
   output logic [11:0] hdr_tag2_vid,
   output logic [23:0] hdr_itag_sid
);
   timeunit 1ns;
   timeprecision 1ns;

   initial begin
      hdr_valid = 1'h0;
      {hdr_channel, hdr_da, hdr_sa, hdr_type_len, hdr_llc_snap, hdr_tag_count} = '0;
      {hdr_tag1_tpid, hdr_tag1_vid, hdr_tag2_tpid, hdr_tag2_vid, hdr_itag_sid} = '0;
   end

   // ****************************************
   // one parsed header, single-cycle pulse
   // ****************************************
   task automatic send(input logic [2:0] ch, input logic [47:0] da, sa,
         input logic [15:0] tl, input logic llc, input logic [1:0] cnt,
         input logic [15:0] tp1, input logic [11:0] v1, input logic [23:0] sid);
      @(posedge clk_sys);
      hdr_valid <= 1'h1;
      hdr_channel <= ch;
      hdr_da <= da;
      hdr_sa <= sa;
      hdr_type_len <= tl;
      hdr_llc_snap <= llc;
      hdr_tag_count <= cnt;
      hdr_tag1_tpid <= tp1;
      hdr_tag1_vid <= v1;
      hdr_tag2_tpid <= 16'h88E7;
      hdr_tag2_vid <= ~v1;
      hdr_itag_sid <= sid;
      @(posedge clk_sys);
      hdr_valid <= 1'h0;
      // fields mean nothing without the pulse, so invert them; tag count and tag 2 fields are left standing
      {hdr_channel, hdr_da, hdr_sa, hdr_type_len, hdr_llc_snap} <= ~{ch, da, sa, tl, llc};
      {hdr_tag1_tpid, hdr_tag1_vid, hdr_itag_sid} <= ~{tp1, v1, sid};
   endtask
endmodule // efm_hdr_src

//--- tb_top.sv
// self-checking bench of the flow matcher and its header source
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   int n_mismatch = 0;
   int n_checks = 0;
   int cyc = 0;
   logic clk_sys = 1'h0;
   logic rst = 1'h1;
   logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
   logic [31:0] s_axi_wdata = 32'h0;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
   logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp, hdr_tag_count, h_cnt;
   logic [31:0] s_axi_rdata;
   logic hdr_valid, hdr_llc_snap, match_valid, h_llc;
   logic [2:0] hdr_channel;
   logic [47:0] hdr_da, hdr_sa, h_da, h_sa;
   logic [15:0] hdr_type_len, hdr_tag1_tpid, hdr_tag2_tpid, h_tl, h_tp1;
   logic [11:0] hdr_tag1_vid, hdr_tag2_vid, h_v1;
   logic [23:0] hdr_itag_sid, h_sid;
   logic [7:0] match_flows, match_group;

   efm_matcher u_efm_matcher (.*);
   efm_hdr_src u_efm_hdr_src (.*);

   always #25 clk_sys = ~clk_sys;

   // ****************************************
   // bus, header and compare tasks
   // ****************************************
   task automatic chk(input string nm, input logic [47:0] e, input logic [47:0] g);
      n_checks++;
      if (g !== e) begin
         n_mismatch++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
      logic ta, tw, da, dw;
      logic [1:0] g;
      da = 1'h0;
      dw = 1'h0;
      @(posedge clk_sys);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      s_axi_bready <= 1'h1;
      // the slave may take the two channels at different edges
      while (!(da && dw)) begin
         @(negedge clk_sys);
         ta = s_axi_awready & !da;
         tw = s_axi_wready & !dw;
         @(posedge clk_sys);
         if (ta) s_axi_awvalid <= 1'h0;
         if (tw) s_axi_wvalid <= 1'h0;
         da = da | ta;
         dw = dw | tw;
      end
      do @(negedge clk_sys); while (s_axi_bvalid !== 1'h1);
      g = s_axi_bresp;
      @(posedge clk_sys);
      s_axi_bready <= 1'h0;
      chk("bresp", 48'(er), 48'(g));
   endtask

   task automatic rd(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
      @(posedge clk_sys);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= 1'h1;
      do @(negedge clk_sys); while (s_axi_arready !== 1'h1);
      @(posedge clk_sys);
      s_axi_arvalid <= 1'h0;
      do @(negedge clk_sys); while (s_axi_rvalid !== 1'h1);
      chk("rdata", 48'(ed), 48'(s_axi_rdata));
      chk("rresp", 48'(er), 48'(s_axi_rresp));
      @(posedge clk_sys);
      s_axi_rready <= 1'h0;
   endtask

   function automatic logic [31:0] ctl(input logic t1, ftm, ver, input logic [1:0] rm, as,
         input logic [2:0] am, input logic [1:0] tc, input logic grp);
      return {12'h000, 4'h1, 1'h0, grp, tc, am, as, rm, ver, ftm, 1'h0, t1, 1'h1};
   endfunction

   task automatic cfg(input logic [2:0] i, input logic [31:0] c, input logic [47:0] ad,
         input logic [31:0] t1, input logic [31:0] rg);
      logic [11:0] b;
      b = 12'h100 + {4'h0, i, 5'h00};
      wr(b, c, 2'h0);
      wr(b + 12'h004, ad[31:0], 2'h0);
      wr(b + 12'h008, {16'h0000, ad[47:32]}, 2'h0);
      wr(b + 12'h00C, t1, 2'h0);
      wr(b + 12'h014, rg, 2'h0);
   endtask

   task automatic probe(input logic [2:0] ch, input logic [7:0] e);
      u_efm_hdr_src.send(ch, h_da, h_sa, h_tl, h_llc, h_cnt, h_tp1, h_v1, h_sid);
      #1;
      chk("match_valid", 48'h1, 48'(match_valid));
      chk("match_flows", 48'(e), 48'(match_flows));
      @(posedge clk_sys);
      #1;
      chk("match_valid", 48'h0, 48'(match_valid));
   endtask

   task automatic wrap_up();
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   always @(posedge clk_sys) begin
      cyc++;
      if (cyc == 5000) begin
         n_mismatch++;
         wrap_up();
      end
   end

   // ****************************************
   // scenarios
   // ****************************************
   task automatic t_flows();
      cfg(3'h0, ctl(1'h0, 1'h0, 1'h0, 2'h0, 2'h2, 3'h1, 2'h0, 1'h0), 48'h0012_3456_789A,
         32'h0, 32'h0);
      cfg(3'h1, ctl(1'h0, 1'h0, 1'h0, 2'h0, 2'h1, 3'h4, 2'h0, 1'h1), 48'h0, 32'h0, 32'h0);
      cfg(3'h2, ctl(1'h0, 1'h1, 1'h0, 2'h0, 2'h0, 3'h0, 2'h0, 1'h0), 48'h0, 32'h0, 32'h0);
      cfg(3'h3, ctl(1'h0, 1'h0, 1'h1, 2'h1, 2'h0, 3'h0, 2'h1, 1'h0), 48'h0,
         32'h0F00_0100, 32'h0130_0120);
      cfg(3'h4, ctl(1'h1, 1'h0, 1'h1, 2'h0, 2'h0, 3'h0, 2'h1, 1'h0), 48'h0,
         32'h0, 32'h0);
      rd(12'h100, ctl(1'h0, 1'h0, 1'h0, 2'h0, 2'h2, 3'h1, 2'h0, 1'h0), 2'h0);
   endtask

   task automatic t_vlan();
      h_cnt = 2'h1;
      probe(3'h0, 8'h0F);
      h_v1 = 12'h130;
      probe(3'h0, 8'h0F);
      h_v1 = 12'h131;
      probe(3'h0, 8'h07);
      h_v1 = 12'h223;
      probe(3'h0, 8'h07);
      h_v1 = 12'h123;
      h_tp1 = 16'h88A8;
      probe(3'h0, 8'h17);
      h_cnt = 2'h2;
      probe(3'h0, 8'h07);
      h_cnt = 2'h0;
   endtask

   task automatic t_addr();
      probe(3'h0, 8'h07);
      chk("match_group", 48'h02, 48'(match_group));
      h_da = 48'h0012_3456_7899;
      h_sa = 48'h0012_3456_789A;
      probe(3'h0, 8'h05);
      h_sa = 48'h0100_0000_0001;
      probe(3'h0, 8'h06);
   endtask

   task automatic t_ftype();
      h_tl = 16'h05FF;
      h_llc = 1'h1;
      probe(3'h0, 8'h04);
      h_llc = 1'h0;
      probe(3'h0, 8'h00);
      h_tl = 16'h0600;
      h_llc = 1'h1;
      probe(3'h0, 8'h00);
      h_llc = 1'h0;
      probe(3'h1, 8'h00);
      probe(3'h0, 8'h06);
      rd(12'h004, 32'h0000_0006, 2'h0);
   endtask

   task automatic t_bb();
      for (int i = 0; i < 5; i++) wr(12'h100 + 12'(i * 32), 32'h0, 2'h0);
      wr(12'h000, 32'h0001_88A8, 2'h0);
      cfg(3'h5, ctl(1'h1, 1'h0, 1'h1, 2'h0, 2'h0, 3'h0, 2'h1, 1'h1), 48'h0,
         32'h0, 32'h0123_0456);
      h_cnt = 2'h1;
      h_tp1 = 16'h88E7;
      h_sid = 24'h123456;
      probe(3'h0, 8'h20);
      chk("match_group", 48'h20, 48'(match_group));
      h_sid = 24'h123457;
      probe(3'h0, 8'h00);
      wr(12'h1A0, ctl(1'h1, 1'h0, 1'h0, 2'h0, 2'h0, 3'h0, 2'h1, 1'h1), 2'h0);
      probe(3'h0, 8'h00);
      wr(12'h1A0, ctl(1'h0, 1'h0, 1'h1, 2'h0, 2'h0, 3'h0, 2'h2, 1'h1), 2'h0);
      h_cnt = 2'h2;
      h_tp1 = 16'h88A8;
      h_sid = 24'h123456;
      probe(3'h0, 8'h20);
   endtask

   initial begin
      h_da = 48'h0012_3456_789A;
      h_sa = 48'h0100_0000_0001;
      h_tl = 16'h0600;
      h_llc = 1'h0;
      h_cnt = 2'h0;
      h_tp1 = 16'h8100;
      h_v1 = 12'h123;
      h_sid = 24'h000000;
      repeat (6) @(posedge clk_sys);
      rst <= 1'h0;
      rd(12'h000, 32'h0000_88A8, 2'h0);
      rd(12'hFFC, 32'h0, 2'h2);
      wr(12'hFFC, 32'hFFFF_FFFF, 2'h2);
      t_flows();
      t_vlan();
      t_addr();
      t_ftype();
      t_bb();
      wrap_up();
   end
endmodule // tb_top
